// *** hw/prsd_pkg.sv ***
// Package of constants for the power-up clock ratio strap decoder.
package prsd_pkg;

   // ------------------------------------------------------------------
   // Strap and ratio widths
   // ------------------------------------------------------------------
   localparam int PLAT_STRAP_W = 4;
   localparam int CORE_STRAP_W = 3;
   localparam int PLAT_MULT_W  = 5;
   // Core ratio is held in half steps: numerator of N:2.
   localparam int CORE_HALF_W  = 4;

   // ------------------------------------------------------------------
   // Platform ratio codes
   // ------------------------------------------------------------------
   localparam logic [3:0] PLAT_CODE_16 = 4'h0;
   localparam logic [3:0] PLAT_CODE_2  = 4'h2;
   localparam logic [3:0] PLAT_CODE_3  = 4'h3;
   localparam logic [3:0] PLAT_CODE_4  = 4'h4;
   localparam logic [3:0] PLAT_CODE_5  = 4'h5;
   localparam logic [3:0] PLAT_CODE_6  = 4'h6;
   localparam logic [3:0] PLAT_CODE_8  = 4'h8;
   localparam logic [3:0] PLAT_CODE_9  = 4'h9;
   localparam logic [3:0] PLAT_CODE_10 = 4'hA;
   localparam logic [3:0] PLAT_CODE_12 = 4'hC;
   localparam logic [3:0] PLAT_CODE_20 = 4'hD;

   // ------------------------------------------------------------------
   // Core ratio codes, value is core:platform in half steps
   // ------------------------------------------------------------------
   localparam logic [2:0] CORE_CODE_4_1 = 3'h0;
   localparam logic [2:0] CORE_CODE_9_2 = 3'h1;
   localparam logic [2:0] CORE_CODE_3_2 = 3'h3;
   localparam logic [2:0] CORE_CODE_2_1 = 3'h4;
   localparam logic [2:0] CORE_CODE_5_2 = 3'h5;
   localparam logic [2:0] CORE_CODE_3_1 = 3'h6;
   localparam logic [2:0] CORE_CODE_7_2 = 3'h7;

   // ------------------------------------------------------------------
   // Reset values and timing
   // ------------------------------------------------------------------
   localparam logic [4:0] PLAT_MULT_RST = 5'h00;
   localparam logic [3:0] CORE_HALF_RST = 4'h0;
   localparam int         SETTLE_NS     = 40;
   localparam int         CLK_MHZ       = 250;
   localparam int         SETTLE_CYC    = (SETTLE_NS * CLK_MHZ + 999) / 1000;

endpackage : prsd_pkg

// *** hw/prsd_sync.sv ***
// Three-stage synchroniser with agreement filter for strap pins.
`timescale 1ns/1ns
`default_nettype none
module prsd_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             sys_clk,
   input  wire logic             sys_rst,
   input  wire logic [WIDTH-1:0] pin_in,
   output logic      [WIDTH-1:0] level_out,
   output logic                  stable_out
);

   // ------------------------------------------------------------------
   // Synchroniser chain
   // ------------------------------------------------------------------
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync2_reg;
   logic [WIDTH-1:0] sync3_reg;
   logic [WIDTH-1:0] level_reg;
   logic             stable_reg;
   logic [1:0]       fill_reg;
   wire              agree  = (sync2_reg == sync3_reg);
   // The chain holds pin samples only after three edges past reset.
   wire              filled = (fill_reg == 2'h3);

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         meta_reg   <= '0;
         sync2_reg  <= '0;
         sync3_reg  <= '0;
         level_reg  <= '0;
         stable_reg <= 1'b0;
         fill_reg   <= 2'h0;
      end else begin
         if (!filled) begin
            fill_reg <= fill_reg + 2'h1;
         end
         meta_reg   <= pin_in;
         sync2_reg  <= meta_reg;
         sync3_reg  <= sync2_reg;
         stable_reg <= agree && filled;
         if (agree) begin
            level_reg <= sync3_reg;
         end
      end
   end

   assign level_out  = level_reg;
   assign stable_out = stable_reg;

endmodule : prsd_sync
`default_nettype wire

// *** hw/prsd_decoder.sv ***
// Power-up clock ratio strap decoder, top level.
`timescale 1ns/1ns
`default_nettype none
module prsd_decoder #(
   parameter int SETTLE_CYC = prsd_pkg::SETTLE_CYC
) (
   input  wire logic       sys_clk,
   input  wire logic       sys_rst,
   input  wire logic [3:0] platform_ratio_strap,
   input  wire logic       bus_control_strap,
   input  wire logic       address_latch_strap,
   input  wire logic       general_line2_strap,
   output logic      [4:0] platform_mult,
   output logic      [4:0] memory_mult_half,
   output logic      [3:0] core_ratio_half,
   output logic            platform_reserved,
   output logic            core_reserved,
   output logic            ratios_valid
);

   // ------------------------------------------------------------------
   // Parameter check
   // ------------------------------------------------------------------
   if (SETTLE_CYC < 1 || SETTLE_CYC > 255) begin : g_bad_settle
      $error("SETTLE_CYC must lie in 1 to 255.");
   end

   // ------------------------------------------------------------------
   // Strap capture
   // ------------------------------------------------------------------
   logic [6:0] strap_level;
   logic       strap_stable;

   prsd_sync #(
      .WIDTH (7)
   ) u_sync (
      .sys_clk    (sys_clk),
      .sys_rst    (sys_rst),
      .pin_in     ({platform_ratio_strap, bus_control_strap,
                    address_latch_strap, general_line2_strap}),
      .level_out  (strap_level),
      .stable_out (strap_stable)
   );

   wire [3:0] plat_code = strap_level[6:3];
   wire [2:0] core_code = strap_level[2:0];

   // ------------------------------------------------------------------
   // Platform ratio decode
   // ------------------------------------------------------------------
   logic [4:0] plat_mult_dec;
   logic       plat_res_dec;

   always_comb begin
      plat_res_dec = 1'b0;
      unique case (plat_code)
         prsd_pkg::PLAT_CODE_16: plat_mult_dec = 5'h10;
         prsd_pkg::PLAT_CODE_2:  plat_mult_dec = 5'h02;
         prsd_pkg::PLAT_CODE_3:  plat_mult_dec = 5'h03;
         prsd_pkg::PLAT_CODE_4:  plat_mult_dec = 5'h04;
         prsd_pkg::PLAT_CODE_5:  plat_mult_dec = 5'h05;
         prsd_pkg::PLAT_CODE_6:  plat_mult_dec = 5'h06;
         prsd_pkg::PLAT_CODE_8:  plat_mult_dec = 5'h08;
         prsd_pkg::PLAT_CODE_9:  plat_mult_dec = 5'h09;
         prsd_pkg::PLAT_CODE_10: plat_mult_dec = 5'h0A;
         prsd_pkg::PLAT_CODE_12: plat_mult_dec = 5'h0C;
         prsd_pkg::PLAT_CODE_20: plat_mult_dec = 5'h14;
         default: begin
            plat_mult_dec = prsd_pkg::PLAT_MULT_RST;
            plat_res_dec  = 1'b1;
         end
      endcase
   end

   // ------------------------------------------------------------------
   // Core ratio decode
   // ------------------------------------------------------------------
   logic [3:0] core_half_dec;
   logic       core_res_dec;

   always_comb begin
      core_res_dec = 1'b0;
      unique case (core_code)
         prsd_pkg::CORE_CODE_4_1: core_half_dec = 4'h8;
         prsd_pkg::CORE_CODE_9_2: core_half_dec = 4'h9;
         prsd_pkg::CORE_CODE_3_2: core_half_dec = 4'h3;
         prsd_pkg::CORE_CODE_2_1: core_half_dec = 4'h4;
         prsd_pkg::CORE_CODE_5_2: core_half_dec = 4'h5;
         prsd_pkg::CORE_CODE_3_1: core_half_dec = 4'h6;
         prsd_pkg::CORE_CODE_7_2: core_half_dec = 4'h7;
         default: begin
            core_half_dec = prsd_pkg::CORE_HALF_RST;
            core_res_dec  = 1'b1;
         end
      endcase
   end

   // ------------------------------------------------------------------
   // Settle counter and one-time latch
   // ------------------------------------------------------------------
   logic [7:0] settle_reg;
   logic       valid_reg;
   logic [4:0] plat_reg;
   logic [3:0] core_reg;
   logic       plat_res_reg;
   logic       core_res_reg;

   wire       settled  = (settle_reg == SETTLE_CYC[7:0]);
   wire       take_now = settled && strap_stable && !valid_reg;
   wire [7:0] settle_next = settled ? settle_reg : settle_reg + 8'h01;

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         settle_reg   <= 8'h00;
         valid_reg    <= 1'b0;
         plat_reg     <= prsd_pkg::PLAT_MULT_RST;
         core_reg     <= prsd_pkg::CORE_HALF_RST;
         plat_res_reg <= 1'b0;
         core_res_reg <= 1'b0;
      end else begin
         settle_reg <= settle_next;
         if (take_now) begin
            valid_reg    <= 1'b1;
            plat_reg     <= plat_mult_dec;
            core_reg     <= core_half_dec;
            plat_res_reg <= plat_res_dec;
            core_res_reg <= core_res_dec;
         end
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   // Memory bus multiplier in half steps equals the platform multiplier.
   assign platform_mult     = plat_reg;
   assign memory_mult_half  = plat_reg;
   assign core_ratio_half   = core_reg;
   assign platform_reserved = plat_res_reg;
   assign core_reserved     = core_res_reg;
   assign ratios_valid      = valid_reg;

endmodule : prsd_decoder
`default_nettype wire

// *** sim/prsd_strap_board.sv ***
// Board strap resistor model for the ratio strap pins.
`timescale 1ns/1ns
`default_nettype none
module prsd_strap_board (
   input  wire logic       sys_clk,
   input  wire logic       bus_active,
   input  wire logic [6:0] strap_sel,
   output logic      [3:0] platform_ratio_strap,
   output logic            bus_control_strap,
   output logic            address_latch_strap,
   output logic            general_line2_strap
);
   logic tog_reg = 1'b0;
   always @(posedge sys_clk) tog_reg <= ~tog_reg;
   assign {platform_ratio_strap, bus_control_strap, address_latch_strap,
      general_line2_strap} = bus_active ? ~strap_sel ^ {7{tog_reg}}
      : strap_sel;
endmodule : prsd_strap_board
`default_nettype wire

// *** sim/prsd_decoder_sva.sv ***
// Port assertions for the clock ratio strap decoder.
`timescale 1ns/1ns
`default_nettype none
module prsd_decoder_chk #(
   parameter int SETTLE_CYC = 10
) (
   input wire logic       sys_clk,
   input wire logic       sys_rst,
   input wire logic [3:0] platform_ratio_strap,
   input wire logic       bus_control_strap,
   input wire logic       address_latch_strap,
   input wire logic       general_line2_strap,
   input wire logic [4:0] platform_mult,
   input wire logic [4:0] memory_mult_half,
   input wire logic [3:0] core_ratio_half,
   input wire logic       platform_reserved,
   input wire logic       core_reserved,
   input wire logic       ratios_valid
);
   logic [3:0] p, ce;
   logic [2:0] c;
   logic [4:0] pe;
   logic [5:0] age_reg;
   assign p = platform_ratio_strap;
   assign c = {bus_control_strap, address_latch_strap, general_line2_strap};
   assign pe = (p == 4'h0) ? 5'h10 : (p == 4'hC) ? 5'h0C : (p == 4'hD) ? 5'h14
      : (p inside {4'h1, 4'h7, 4'hB, 4'hE, 4'hF}) ? 5'h00 : {1'b0, p};
   assign ce = (c < 3'h2) ? {3'h4, c[0]} : (c == 3'h2) ? 4'h0 : {1'b0, c};
   always_ff @(posedge sys_clk or posedge sys_rst)
      if (sys_rst) age_reg <= 6'h00;
      else if (age_reg != 6'h3F) age_reg <= age_reg + 6'h01;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   a_plat_decode: assert property ($rose(ratios_valid) |->
      platform_mult == $past(pe, 5)) else $error("platform ratio");
   a_plat_flag: assert property ($rose(ratios_valid) |->
      platform_reserved == ($past(pe, 5) == 5'h00))
      else $error("platform flag");
   a_core_decode: assert property ($rose(ratios_valid) |->
      {core_reserved, core_ratio_half} ==
      {$past(ce, 5) == 4'h0, $past(ce, 5)}) else $error("core");
   a_mem_half: assert property (ratios_valid |->
      memory_mult_half == platform_mult) else $error("memory ratio");
   a_ratio_hold: assert property ($past(ratios_valid) |-> $stable({
      ratios_valid, platform_mult, memory_mult_half, core_ratio_half,
      platform_reserved, core_reserved})) else $error("ratio changed");
   a_latch_early: assert property (ratios_valid |->
      age_reg > SETTLE_CYC) else $error("latched early");
   a_latch_late: assert property (age_reg == 6'h28 |->
      ratios_valid) else $error("never latched");
   c_plat_rsv: cover property ($rose(ratios_valid) && platform_reserved);
   c_core_rsv: cover property ($rose(ratios_valid) && core_reserved);
   c_plain: cover property ($rose(ratios_valid) && !platform_reserved
      && !core_reserved);
endmodule : prsd_decoder_chk
`default_nettype wire

// *** sim/prsd_decoder_tb_top.sv ***
// Self-checking testbench for the clock ratio strap decoder.
`timescale 1ns/1ns
`default_nettype none
module prsd_decoder_tb_top;
   localparam int SETTLE = 4;
   localparam int OSC_MHZ = 100;
   logic       sys_clk = 1'b0, sys_rst = 1'b1, bus_active = 1'b0;
   logic       bus_control_strap, address_latch_strap, general_line2_strap;
   logic       platform_reserved, core_reserved, ratios_valid;
   logic [3:0] platform_ratio_strap, core_ratio_half;
   logic [4:0] platform_mult, memory_mult_half;
   logic [6:0] strap_sel = 7'h00;
   int         failures = 0, comparisons = 0, n;
   always #2 sys_clk = ~sys_clk;
   prsd_strap_board board (
      .sys_clk              (sys_clk),
      .bus_active           (bus_active),
      .strap_sel            (strap_sel),
      .platform_ratio_strap (platform_ratio_strap),
      .bus_control_strap    (bus_control_strap),
      .address_latch_strap  (address_latch_strap),
      .general_line2_strap  (general_line2_strap)
   );
   prsd_decoder #(
      .SETTLE_CYC (SETTLE)
   ) dut (
      .sys_clk              (sys_clk),
      .sys_rst              (sys_rst),
      .platform_ratio_strap (platform_ratio_strap),
      .bus_control_strap    (bus_control_strap),
      .address_latch_strap  (address_latch_strap),
      .general_line2_strap  (general_line2_strap),
      .platform_mult        (platform_mult),
      .memory_mult_half     (memory_mult_half),
      .core_ratio_half      (core_ratio_half),
      .platform_reserved    (platform_reserved),
      .core_reserved        (core_reserved),
      .ratios_valid         (ratios_valid)
   );
   function automatic logic [5:0] pexp(input logic [3:0] p);
      if (p inside {4'h1, 4'h7, 4'hB, 4'hE, 4'hF}) return 6'h20;
      return (p == 4'h0) ? 6'h10 : (p == 4'hC) ? 6'h0C : (p == 4'hD) ? 6'h14
         : {2'b00, p};
   endfunction : pexp
   function automatic logic [5:0] cexp(input logic [2:0] c);
      return (c == 3'h2) ? 6'h20 : (c < 3'h2) ? 6'h08 + c : {3'b000, c};
   endfunction : cexp
   // Board choice check: platform rate is the DDR data rate.
   function automatic bit legal(input logic [3:0] p, input logic [2:0] c);
      int plat;
      int core;
      plat = OSC_MHZ * int'(pexp(p));
      core = plat * int'(cexp(c)) / 2;
      return pexp(p) < 6'h20 && cexp(c) < 6'h20
         && plat >= 333
         && core >= 800 && core <= 1333
         && plat / 2 >= 166 && plat / 2 <= 266
         && (OSC_MHZ <= 100 || core >= 1200);
   endfunction : legal
   task automatic check(input logic [5:0] seen, input logic [5:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH at %0t ns: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic results();
      $display("comparisons %0d, failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : results
   task automatic run(input logic [3:0] p, input logic [2:0] c);
      logic [5:0] e;
      e = pexp(p);
      sys_rst = 1'b1;
      bus_active = 1'b0;
      strap_sel = {p, c};
      repeat (12) @(negedge sys_clk);
      check({5'h00, ratios_valid}, 6'h00);
      sys_rst = 1'b0;
      for (n = 0; n < 40 && ratios_valid !== 1'b1; n++) @(negedge sys_clk);
      check({5'h00, ratios_valid}, 6'h01);
      repeat (2) begin
         check({platform_reserved, platform_mult}, e);
         check({1'b0, memory_mult_half}, {1'b0, e[4:0]});
         check({core_reserved, 1'b0, core_ratio_half}, cexp(c));
         bus_active = 1'b1;
         repeat (20) @(negedge sys_clk);
      end
      $display("test with straps %h %h done", p, c);
   endtask : run
   initial begin
      logic [3:0] rp;
      logic [2:0] rc;
      void'($urandom(86));
      for (int i = 0; i < 16; i++) run(4'(i), 3'(i));
      for (int i = 0; i < 8; i++) begin
         do begin
            rp = 4'($urandom);
            rc = 3'($urandom);
         end while (!legal(rp, rc));
         run(rp, rc);
      end
      results();
   end
   initial begin
      #20000;
      failures++;
      results();
   end
endmodule : prsd_decoder_tb_top
bind prsd_decoder prsd_decoder_chk #(.SETTLE_CYC(SETTLE_CYC)) chk (
   .sys_clk              (sys_clk),
   .sys_rst              (sys_rst),
   .platform_ratio_strap (platform_ratio_strap),
   .bus_control_strap    (bus_control_strap),
   .address_latch_strap  (address_latch_strap),
   .general_line2_strap  (general_line2_strap),
   .platform_mult        (platform_mult),
   .memory_mult_half     (memory_mult_half),
   .core_ratio_half      (core_ratio_half),
   .platform_reserved    (platform_reserved),
   .core_reserved        (core_reserved),
   .ratios_valid         (ratios_valid)
);
`default_nettype wire
